// ===== core/ejmd_cfg.svh
// Constants for the ejector mode and threshold display block
`ifndef EJMD_CFG_SVH
`define EJMD_CFG_SVH
`define EJMD_CLK_HZ 100000000
`define EJMD_HOLD_MS 3000
`define EJMD_HOLD_CYC ((`EJMD_CLK_HZ / 1000) * `EJMD_HOLD_MS)
`define EJMD_FLASH_MS 250
`define EJMD_FLASH_CYC ((`EJMD_CLK_HZ / 1000) * `EJMD_FLASH_MS)
`define EJMD_CAL_PERCENT 3
`define EJMD_DISP_NONE 2'h0
`define EJMD_DISP_MANUAL 2'h1
`define EJMD_DISP_CAL_ERR 2'h2
`endif

// ===== core/ejmd_pkg.sv
// Types for the ejector mode and threshold display block
package ejmd_pkg;
  typedef enum logic [2:0] {
    EJMD_AUTO = 3'h1,
    EJMD_MANUAL = 3'h2,
    EJMD_SETUP = 3'h4
  } ejmd_mode_t;
endpackage : ejmd_pkg

// ===== core/ejmd_hyst.sv
// Threshold comparator with hysteresis
module ejmd_hyst #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [W-1:0] vac_i,
  input wire logic [W-1:0] point_i,
  input wire logic [W-1:0] hyst_i,
  // Result
  output logic on_o
);
  typedef struct packed {
    logic on;
  } ejmd_hyst_st_t;
  ejmd_hyst_st_t s_q;
  ejmd_hyst_st_t s_d;
  logic [W:0] low;
  assign low = {1'b0, point_i} - {1'b0, hyst_i};
  always_comb begin
    s_d = s_q;
    if (vac_i > point_i) begin
      s_d.on = 1'b1;
    end else if (low[W] || ({1'b0, vac_i} < low)) begin
      s_d.on = low[W] ? s_q.on : 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign on_o = s_q.on;
endmodule : ejmd_hyst

// ===== core/ejmd_top.sv
// Ejector mode control, process and threshold indicators
`include "ejmd_cfg.svh"
module ejmd_top #(
  parameter int VW = 12,
  parameter int FULL_SCALE = 1000,
  parameter int HOLD_CYC = `EJMD_HOLD_CYC,
  parameter int FLASH_CYC = `EJMD_FLASH_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Controller inputs
  input wire logic suction_in_i,
  input wire logic blow_in_i,
  input wire logic iolink_mode_i,
  input wire logic setup_req_i,
  input wire logic normally_closed_i,
  // Keypad
  input wire logic key_menu_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  // Sensor and configuration
  input wire logic [VW-1:0] vac_raw_i,
  input wire logic [VW-1:0] regulation_point_i,
  input wire logic [VW-1:0] regulation_hysteresis_i,
  input wire logic [VW-1:0] component_check_point_i,
  input wire logic [VW-1:0] component_check_hysteresis_i,
  input wire logic regulation_on_i,
  input wire logic regulation_with_leak_watch_i,
  input wire logic param_wr_i,
  input wire logic cal_req_i,
  // Valves and indicators
  output logic suction_valve_o,
  output logic blow_valve_o,
  output logic led_suction_o,
  output logic led_blow_o,
  output logic led_reg_o,
  output logic led_check_o,
  output logic check_out_o,
  output logic pd_reg_o,
  output logic pd_check_o,
  output logic [VW-1:0] vac_o,
  // Status
  output logic [1:0] disp_code_o,
  output logic valve_prot_en_o,
  output logic param_wr_ok_o,
  output logic manual_o,
  output logic setup_o
);
  localparam int CAL_LIM = FULL_SCALE * `EJMD_CAL_PERCENT / 100;
  // Clamp and counters cannot serve these sizes
  if (VW < 4 || FULL_SCALE >= (1 << VW) || HOLD_CYC < 1
      || FLASH_CYC < 1) begin : g_bad_param
    $error("ejmd_top: bad parameters");
  end

  typedef struct packed {
    ejmd_pkg::ejmd_mode_t mode;
    logic [31:0] hold_cnt;
    logic [31:0] flash_cnt;
    logic flash;
    logic man_suck;
    logic man_blow;
    logic up_q;
    logic suck_in_q;
    logic blow_in_q;
    logic regen;
    logic signed [VW:0] offset;
    logic [1:0] disp;
    logic suction_valve;
    logic blow_valve;
    logic led_suction;
    logic led_blow;
    logic led_reg;
    logic led_check;
    logic pd_reg;
    logic pd_check;
    logic [VW-1:0] vac;
    logic prot;
    logic wr_ok;
  } ejmd_st_t;

  ejmd_st_t s_q;
  ejmd_st_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic reg_hit;
  logic chk_hit;
  logic signed [VW+1:0] vac_corr;
  logic signed [VW+1:0] cal_try;
  logic ext_suck;
  logic reg_cfg;
  logic setup_ok;

  // Second release flop gives a clean internal reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Corrected vacuum, clamped to the unsigned range
  assign vac_corr = $signed({2'b00, vac_raw_i}) - (VW + 2)'(s_q.offset);
  assign cal_try = $signed({2'b00, vac_raw_i});

  ejmd_hyst #(.W(VW)) u_reg (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .vac_i(s_q.vac),
    .point_i(regulation_point_i),
    .hyst_i(regulation_hysteresis_i),
    .on_o(reg_hit)
  );
  ejmd_hyst #(.W(VW)) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .vac_i(s_q.vac),
    .point_i(component_check_point_i),
    .hyst_i(component_check_hysteresis_i),
    .on_o(chk_hit)
  );

  assign ext_suck = normally_closed_i ? suction_in_i
                    : !suction_in_i;
  assign reg_cfg = regulation_on_i || regulation_with_leak_watch_i;
  // Process bits take priority over setup
  assign setup_ok = setup_req_i && iolink_mode_i && !suction_in_i
                    && !blow_in_i;

  always_comb begin
    s_d = s_q;
    s_d.suck_in_q = suction_in_i;
    s_d.blow_in_q = blow_in_i;
    s_d.up_q = key_up_i;
    // Flash divider runs free so both LEDs blink in step
    if (s_q.flash_cnt >= 32'(FLASH_CYC - 1)) begin
      s_d.flash_cnt = '0;
      s_d.flash = !s_q.flash;
    end else begin
      s_d.flash_cnt = s_q.flash_cnt + 32'h1;
    end
    s_d.disp = (s_q.disp == `EJMD_DISP_MANUAL) ? `EJMD_DISP_NONE : s_q.disp;
    unique case (s_q.mode)
      ejmd_pkg::EJMD_AUTO: begin
        if (key_up_i && key_down_i) begin
          s_d.disp = `EJMD_DISP_MANUAL;
          if (s_q.hold_cnt >= 32'(HOLD_CYC)) begin
            s_d.mode = ejmd_pkg::EJMD_MANUAL;
            s_d.man_suck = s_q.suction_valve;
            s_d.man_blow = s_q.blow_valve;
            s_d.hold_cnt = '0;
          end else begin
            s_d.hold_cnt = s_q.hold_cnt + 32'h1;
          end
        end else begin
          s_d.hold_cnt = '0;
          if (setup_ok) begin
            s_d.mode = ejmd_pkg::EJMD_SETUP;
          end
        end
      end
      ejmd_pkg::EJMD_MANUAL: begin
        // Entry chord still held: keys must not act yet
        if (key_up_i && key_down_i) begin
          s_d.man_suck = s_q.man_suck;
        end else if (key_up_i && !s_q.up_q) begin
          s_d.man_suck = !s_q.man_suck;
          s_d.man_blow = 1'b0;
        end else if (key_down_i) begin
          s_d.man_suck = 1'b0;
          s_d.man_blow = 1'b1;
        end else begin
          s_d.man_blow = 1'b0;
        end
        if (key_menu_i || suction_in_i != s_q.suck_in_q
            || blow_in_i != s_q.blow_in_q) begin
          s_d.mode = ejmd_pkg::EJMD_AUTO;
          s_d.man_suck = 1'b0;
          s_d.man_blow = 1'b0;
        end
      end
      ejmd_pkg::EJMD_SETUP: begin
        if (!setup_ok) begin
          s_d.mode = ejmd_pkg::EJMD_AUTO;
        end
      end
      default: s_d.mode = ejmd_pkg::EJMD_AUTO;
    endcase
    // Zero-point calibration, rejected outside the window
    if (cal_req_i && s_q.mode == ejmd_pkg::EJMD_AUTO) begin
      if (cal_try > (VW + 2)'(CAL_LIM)) begin
        s_d.disp = `EJMD_DISP_CAL_ERR;
      end else begin
        s_d.offset = {1'b0, vac_raw_i};
        s_d.disp = `EJMD_DISP_NONE;
      end
    end
    if (vac_corr < 0) begin
      s_d.vac = '0;
    end else begin
      s_d.vac = vac_corr[VW-1:0];
    end
    // Regulation gate, also in manual and setup
    s_d.regen = reg_cfg && reg_hit;
    if (s_q.mode == ejmd_pkg::EJMD_MANUAL) begin
      s_d.blow_valve = s_q.man_blow;
      s_d.suction_valve = s_q.man_suck && !s_q.man_blow && !s_d.regen;
    end else begin
      s_d.blow_valve = blow_in_i;
      s_d.suction_valve = ext_suck && !blow_in_i && !s_d.regen;
    end
    s_d.led_suction = s_d.suction_valve || (s_q.mode == ejmd_pkg::EJMD_MANUAL
                      ? s_q.man_suck : ext_suck && !blow_in_i);
    s_d.led_blow = s_d.blow_valve;
    if (s_q.mode != ejmd_pkg::EJMD_AUTO) begin
      s_d.led_reg = s_q.flash;
      s_d.led_check = s_q.flash;
    end else begin
      s_d.led_reg = reg_hit;
      s_d.led_check = reg_hit || chk_hit;
    end
    s_d.pd_reg = reg_hit;
    s_d.pd_check = chk_hit;
    s_d.prot = s_q.mode == ejmd_pkg::EJMD_AUTO;
    s_d.wr_ok = s_q.mode == ejmd_pkg::EJMD_AUTO && param_wr_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q.mode <= ejmd_pkg::EJMD_AUTO;
      s_q.hold_cnt <= '0;
      s_q.flash_cnt <= '0;
      s_q.flash <= 1'b0;
      s_q.man_suck <= 1'b0;
      s_q.man_blow <= 1'b0;
      s_q.up_q <= 1'b0;
      s_q.suck_in_q <= 1'b0;
      s_q.blow_in_q <= 1'b0;
      s_q.regen <= 1'b0;
      s_q.offset <= '0;
      s_q.disp <= `EJMD_DISP_NONE;
      s_q.suction_valve <= 1'b0;
      s_q.blow_valve <= 1'b0;
      s_q.led_suction <= 1'b0;
      s_q.led_blow <= 1'b0;
      s_q.led_reg <= 1'b0;
      s_q.led_check <= 1'b0;
      s_q.pd_reg <= 1'b0;
      s_q.pd_check <= 1'b0;
      s_q.vac <= '0;
      s_q.prot <= 1'b1;
      s_q.wr_ok <= 1'b1;
    end else begin
      s_q.mode <= s_d.mode;
      s_q.hold_cnt <= s_d.hold_cnt;
      s_q.flash_cnt <= s_d.flash_cnt;
      s_q.flash <= s_d.flash;
      s_q.man_suck <= s_d.man_suck;
      s_q.man_blow <= s_d.man_blow;
      s_q.up_q <= s_d.up_q;
      s_q.suck_in_q <= s_d.suck_in_q;
      s_q.blow_in_q <= s_d.blow_in_q;
      s_q.regen <= s_d.regen;
      s_q.offset <= s_d.offset;
      s_q.disp <= s_d.disp;
      s_q.suction_valve <= s_d.suction_valve;
      s_q.blow_valve <= s_d.blow_valve;
      s_q.led_suction <= s_d.led_suction;
      s_q.led_blow <= s_d.led_blow;
      s_q.led_reg <= s_d.led_reg;
      s_q.led_check <= s_d.led_check;
      s_q.pd_reg <= s_d.pd_reg;
      s_q.pd_check <= s_d.pd_check;
      s_q.vac <= s_d.vac;
      s_q.prot <= s_d.prot;
      s_q.wr_ok <= s_d.wr_ok;
    end
  end

  assign suction_valve_o = s_q.suction_valve;
  assign blow_valve_o = s_q.blow_valve;
  assign led_suction_o = s_q.led_suction;
  assign led_blow_o = s_q.led_blow;
  assign led_reg_o = s_q.led_reg;
  assign led_check_o = s_q.led_check;
  assign check_out_o = s_q.pd_check;
  assign pd_reg_o = s_q.pd_reg;
  assign pd_check_o = s_q.pd_check;
  assign vac_o = s_q.vac;
  assign disp_code_o = s_q.disp;
  assign valve_prot_en_o = s_q.prot;
  assign param_wr_ok_o = s_q.wr_ok;
  // One-hot mode bits feed the flags straight from the register
  assign manual_o = s_q.mode[1];
  assign setup_o = s_q.mode[2];

  a_idle_dark: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) $past(s_q.mode == ejmd_pkg::EJMD_AUTO
    && !ext_suck && !blow_in_i) |-> !s_q.led_suction && !s_q.led_blow)
    else $error("process LEDs lit while idle");
  a_blow_led: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) $past(s_q.mode) == ejmd_pkg::EJMD_AUTO
    |-> s_q.led_blow == $past(blow_in_i))
    else $error("blow LED does not follow blow-off");
  a_check_led: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) $past(s_q.mode) == ejmd_pkg::EJMD_AUTO
    && $past(reg_hit) |-> s_q.led_check)
    else $error("check LED dark above regulation point");
  a_manual_entry: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) $rose(manual_o) |-> $past(key_up_i)
    && $past(key_down_i)) else $error("manual entered without keys");
  a_manual_prot: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) manual_o |=> !s_q.prot)
    else $error("protection on in manual");
  a_manual_exit: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) manual_o && key_menu_i |=> !manual_o)
    else $error("menu key did not exit manual");
  a_setup_gate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) setup_o && !iolink_mode_i |=> !setup_o)
    else $error("setup held outside IO-Link");
  a_wr_auto: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n) s_q.wr_ok |-> $past(s_q.mode)
    == ejmd_pkg::EJMD_AUTO) else $error("writes allowed outside automatic");
endmodule : ejmd_top

// ===== verif/ejmd_ctrl_model.sv
// Machine controller model: process bits and set-up request
module ejmd_ctrl_model (
  // Clock
  input wire logic clk_sys_i,
  // Commands from the bench
  input wire logic suck_cmd_i,
  input wire logic blow_cmd_i,
  input wire logic setup_cmd_i,
  input wire logic iolink_cmd_i,
  // Lines to the ejector
  output logic suction_in_o,
  output logic blow_in_o,
  output logic setup_req_o,
  output logic iolink_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Process bits and set-up bit change only just after an edge
  always @(posedge clk_sys_i) begin
    suction_in_o <= suck_cmd_i;
    blow_in_o <= blow_cmd_i;
    setup_req_o <= setup_cmd_i;
    iolink_mode_o <= iolink_cmd_i;
  end
endmodule : ejmd_ctrl_model

// ===== verif/ejmd_top_tb.sv
// Self-checking bench for the ejector mode and threshold block
`include "ejmd_cfg.svh"
module ejmd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic suck = 0, blow = 0, setup = 0, iol = 0, nc = 1;
  logic k_menu = 0, k_up = 0, k_down = 0;
  logic [11:0] vac = '0;
  logic reg_on = 0, leak_w = 0, cal = 0, pwr = 1;
  logic s_in, b_in, su_req, iol_m;
  logic sv, bv, l_s, l_b, l_r, l_c, c_out, p_r, p_c, man, su, vp, pw_ok;
  logic [11:0] vac_o;
  logic [1:0] disp;
  int error_cnt = 0;
  int n_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ejmd_ctrl_model ejmd_ctrl_model_i (.clk_sys_i(clk_sys_i),
    .suck_cmd_i(suck), .blow_cmd_i(blow), .setup_cmd_i(setup),
    .iolink_cmd_i(iol), .suction_in_o(s_in), .blow_in_o(b_in),
    .setup_req_o(su_req), .iolink_mode_o(iol_m));
  ejmd_top #(.HOLD_CYC(HOLD), .FLASH_CYC(4)) ejmd_top_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .suction_in_i(s_in),
    .blow_in_i(b_in), .iolink_mode_i(iol_m), .setup_req_i(su_req),
    .normally_closed_i(nc), .key_menu_i(k_menu), .key_up_i(k_up),
    .key_down_i(k_down), .vac_raw_i(vac), .regulation_point_i(12'hc8),
    .regulation_hysteresis_i(12'h1e), .component_check_point_i(12'h64),
    .component_check_hysteresis_i(12'h14), .regulation_on_i(reg_on),
    .regulation_with_leak_watch_i(leak_w), .param_wr_i(pwr),
    .cal_req_i(cal), .suction_valve_o(sv), .blow_valve_o(bv),
    .led_suction_o(l_s), .led_blow_o(l_b), .led_reg_o(l_r),
    .led_check_o(l_c), .check_out_o(c_out), .pd_reg_o(p_r),
    .pd_check_o(p_c), .vac_o(vac_o), .disp_code_o(disp),
    .valve_prot_en_o(vp), .param_wr_ok_o(pw_ok), .manual_o(man),
    .setup_o(su));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic set_vac(input logic [11:0] v, input logic r,
                         input logic c);
    @(posedge clk_sys_i);
    vac <= v;
    cyc(6);
    chk(l_r, r);
    chk(l_c, c);
    chk({p_r, p_c, c_out}, {r, c, c});
  endtask : set_vac
  task automatic tap(input int k);
    @(posedge clk_sys_i);
    if (k == 0) k_up <= 1;
    else if (k == 1) k_down <= 1;
    else k_menu <= 1;
    cyc(2);
    {k_up, k_down, k_menu} <= 3'h0;
    cyc(4);
  endtask : tap
  task automatic flash_chk();
    int flips;
    logic last;
    flips = 0;
    last = l_r;
    repeat (24) begin
      cyc(1);
      if (l_r !== last) flips++;
      last = l_r;
    end
    chk(12'(flips > 2), 12'h1);
  endtask : flash_chk
  task automatic enter_manual(input logic exp_sv);
    int i;
    @(posedge clk_sys_i);
    {k_up, k_down} <= 2'h3;
    cyc(HOLD / 2);
    chk(man, 0);
    chk(disp, `EJMD_DISP_MANUAL);
    for (i = 0; i < 40 && man !== 1'b1; i++) cyc(1);
    if (i == 40) begin
      error_cnt++;
      complete_run();
    end
    chk(sv, exp_sv);
    @(posedge clk_sys_i);
    {k_up, k_down} <= 2'h0;
    cyc(3);
  endtask : enter_manual
  task automatic t_reset();
    chk({man, su, vp, pw_ok, l_s, l_b}, 12'h0c);
    @(posedge clk_sys_i);
    pwr <= 0;
    cyc(3);
    chk(pw_ok, 0);
    @(posedge clk_sys_i);
    pwr <= 1;
    cyc(3);
  endtask : t_reset
  task automatic t_process();
    chk({sv, bv, l_s, l_b}, 12'h0);
    @(posedge clk_sys_i);
    suck <= 1;
    cyc(4);
    chk({sv, l_s, l_b}, 12'h6);
    @(posedge clk_sys_i);
    {suck, blow} <= 2'h1;
    cyc(4);
    chk({sv, bv, l_s, l_b}, 12'h5);
    @(posedge clk_sys_i);
    {suck, blow, nc} <= 3'h4;
    cyc(4);
    chk(sv, 0);
    @(posedge clk_sys_i);
    {suck, nc} <= 2'h1;
    cyc(4);
  endtask : t_process
  task automatic t_thresh();
    set_vac(12'h64, 0, 0);
    set_vac(12'h96, 0, 1);
    set_vac(12'hc8, 0, 1);
    set_vac(12'hfa, 1, 1);
    set_vac(12'hab, 1, 1);
    set_vac(12'ha0, 0, 1);
    set_vac(12'h51, 0, 1);
    set_vac(12'h46, 0, 0);
  endtask : t_thresh
  task automatic t_regul();
    @(posedge clk_sys_i);
    {reg_on, suck} <= 2'h3;
    set_vac(12'hfa, 1, 1);
    chk(sv, 0);
    set_vac(12'hb4, 1, 1);
    chk(sv, 0);
    set_vac(12'ha0, 0, 1);
    chk(sv, 1);
    @(posedge clk_sys_i);
    {reg_on, suck, vac} <= 14'h0;
    cyc(6);
  endtask : t_regul
  task automatic t_manual();
    enter_manual(0);
    chk({vp, pw_ok}, 12'h0);
    flash_chk();
    tap(0);
    chk({sv, l_s}, 12'h3);
    tap(0);
    chk(sv, 0);
    tap(0);
    @(posedge clk_sys_i);
    {leak_w, vac} <= {1'b1, 12'hfa};
    cyc(6);
    chk(sv, 0);
    @(posedge clk_sys_i);
    {leak_w, vac, k_down} <= 14'h1;
    cyc(4);
    chk({sv, bv}, 12'h1);
    @(posedge clk_sys_i);
    k_down <= 0;
    cyc(4);
    chk(bv, 0);
    tap(2);
    chk(man, 0);
    @(posedge clk_sys_i);
    suck <= 1;
    cyc(4);
    enter_manual(1);
    chk(sv, 1);
    @(posedge clk_sys_i);
    blow <= 1;
    cyc(4);
    chk({man, bv}, 12'h1);
    @(posedge clk_sys_i);
    {suck, blow} <= 2'h0;
    cyc(4);
  endtask : t_manual
  task automatic t_setup();
    @(posedge clk_sys_i);
    setup <= 1;
    cyc(4);
    chk(su, 0);
    @(posedge clk_sys_i);
    iol <= 1;
    cyc(4);
    chk({su, vp}, 12'h2);
    flash_chk();
    @(posedge clk_sys_i);
    suck <= 1;
    cyc(4);
    chk(su, 0);
    @(posedge clk_sys_i);
    {suck, setup} <= 2'h0;
    cyc(4);
  endtask : t_setup
  task automatic t_cal();
    @(posedge clk_sys_i);
    // Circuit vented: raw reading is the sensor's zero error
    {vac, cal} <= {12'h1f, 1'b1};
    @(posedge clk_sys_i);
    cal <= 0;
    cyc(4);
    chk(disp, `EJMD_DISP_CAL_ERR);
    chk(vac_o, 12'h01f);
    @(posedge clk_sys_i);
    {vac, cal} <= {12'h1e, 1'b1};
    @(posedge clk_sys_i);
    cal <= 0;
    cyc(4);
    chk(disp, `EJMD_DISP_NONE);
    chk(vac_o, 12'h0);
    @(posedge clk_sys_i);
    vac <= 12'h28;
    cyc(4);
    chk(vac_o, 12'h00a);
  endtask : t_cal
  initial begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1;
    cyc(4);
    t_reset();
    t_process();
    t_thresh();
    t_regul();
    t_manual();
    t_setup();
    t_cal();
    complete_run();
  end
endmodule : ejmd_top_tb
